// [include/adc_readout_pkg.sv]
// Shared constants and types for the converter serial readout link.
package adc_readout_pkg;

   localparam int         DATA_W        = 18;
   localparam int         SYS_CLK_NS    = 20;
   localparam int         T_CONV_MIN_NS = 500;
   localparam int         T_CONV_MAX_NS = 710;

   // Conversion length rounds up, the host's early limit rounds down.
   localparam logic [7:0] CONV_CYC      = 8'((T_CONV_MAX_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [7:0] CONV_MIN_CYC  = 8'(T_CONV_MIN_NS / SYS_CLK_NS);

   localparam logic [7:0] FRAME_PLAIN   = 8'h12;
   localparam logic [7:0] FRAME_BUSY    = 8'h13;
   localparam logic [7:0] SCLK_HALF_CYC = 8'h08;
   localparam logic [7:0] ARM_CYC       = 8'h04;
   localparam logic [7:0] HOST_DROP_CYC = 8'(ARM_CYC + CONV_MIN_CYC / 2);
   localparam logic [7:0] HOST_WAIT_CYC = 8'(ARM_CYC + CONV_CYC + 8'h10);

   localparam logic       RST_CONV      = 1'b0;
   localparam logic       RST_SDI       = 1'b1;
   localparam logic       RST_SCLK      = 1'b0;
   localparam logic       RST_DOUT      = 1'b1;

   typedef enum logic [3:0] {
      D_IDLE  = 4'b0001,
      D_CONV  = 4'b0010,
      D_ACQ   = 4'b0100,
      D_SHIFT = 4'b1000
   } dev_state_t;

   typedef enum logic [4:0] {
      H_IDLE  = 5'b00001,
      H_CONV  = 5'b00010,
      H_WAIT  = 5'b00100,
      H_SHIFT = 5'b01000,
      H_DONE  = 5'b10000
   } host_state_t;

   typedef enum logic [4:0] {
      M_3W      = 5'b00001,
      M_3W_BUSY = 5'b00010,
      M_4W      = 5'b00100,
      M_4W_BUSY = 5'b01000,
      M_DAISY   = 5'b10000
   } host_mode_t;

endpackage

// [include/adc_link_if.sv]
// Pin-level link between the converter readout end and its host.
`timescale 1ns/100ps
interface adc_link_if;
   logic conv_start;
   logic sdi;
   logic sclk;
   logic dout_o;
   logic dout_oe;
   logic dout;

   // The pull-up holds the line high whenever the converter releases it.
   assign dout = dout_oe ? dout_o : 1'b1;

   modport device (
      input  conv_start,
      input  sdi,
      input  sclk,
      output dout_o,
      output dout_oe
   );

   modport host (
      output conv_start,
      output sdi,
      output sclk,
      input  dout
   );
endinterface

// [core/adc_pin_sync.sv]
// Three-stage synchroniser whose output follows only once stages two and three agree.
`timescale 1ns/100ps
module adc_pin_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_arst_n,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] q_ff;

   // The agreement check filters a single-cycle glitch out of stage two.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         q_ff  <= RST_VAL;
      end else begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q_ff);
      end
   end

   assign o_q = q_ff;
endmodule // adc_pin_sync

// [core/adc_readout_device.sv]
// Converter end of the serial readout link: mode selection, conversion timing, output shifter.
`timescale 1ns/100ps
module adc_readout_device
   import adc_readout_pkg::*;
(
   adc_link_if.device              link,
   input  wire logic               i_sys_clk,
   input  wire logic               i_arst_n,
   input  wire logic [DATA_W-1:0]  i_sample,
   output logic                    o_converting,
   output logic                    o_daisy_mode
);
   logic [2:0]        pin_q;
   logic [2:0]        pin_d_ff;
   logic              cv_q;
   logic              din_q;
   logic              sclk_q;
   logic              cv_rise;
   logic              cv_fall;
   logic              din_rise;
   logic              din_fall;
   logic              sclk_fall;
   dev_state_t        state_ff;
   logic [7:0]        cnt_ff;
   logic [7:0]        edge_ff;
   logic [7:0]        frame_len;
   logic [DATA_W:0]   sreg_ff;
   logic [DATA_W-1:0] sample_ff;
   logic              oe_ff;
   logic              daisy_ff;
   logic              busy_ff;
   logic              cs_din_ff;
   logic              conv_ff;
   logic              start;
   logic              conv_done;
   logic              busy_end;
   logic              select;
   logic              frame_last;
   logic              shift_end;

   // Start, data input and serial clock all come from the far side's domain.
   adc_pin_sync #(
      .WIDTH   (3),
      .RST_VAL ({RST_SCLK, RST_SDI, RST_CONV})
   ) u_pin_sync (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     ({link.sclk, link.sdi, link.conv_start}),
      .o_q       (pin_q)
   );

   // Previous filtered levels, for edge detection.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_d_ff <= {RST_SCLK, RST_SDI, RST_CONV};
      end else begin
         pin_d_ff <= pin_q;
      end
   end

   assign cv_q      = pin_q[0];
   assign din_q     = pin_q[1];
   assign sclk_q    = pin_q[2];
   assign cv_rise   = cv_q & ~pin_d_ff[0];
   assign cv_fall   = ~cv_q & pin_d_ff[0];
   assign din_rise  = din_q & ~pin_d_ff[1];
   assign din_fall  = ~din_q & pin_d_ff[1];
   assign sclk_fall = ~sclk_q & pin_d_ff[2];

   // A start edge during a conversion is ignored; the internal clock finishes it.
   assign start      = cv_rise && (state_ff != D_CONV);
   assign conv_done  = (state_ff == D_CONV) && (cnt_ff == CONV_CYC - 8'h01);
   // Outside daisy mode, busy is chosen by whichever select line is low when conversion ends.
   assign busy_end   = !daisy_ff && (!cv_q || !din_q);
   assign select     = (state_ff == D_ACQ) && (cv_fall || din_fall);
   assign frame_len  = busy_ff ? FRAME_BUSY : FRAME_PLAIN;
   assign frame_last = sclk_fall && (edge_ff == frame_len - 8'h01);
   // Outside daisy mode the shifter lets go after the last falling edge or when its select rises.
   assign shift_end  = !daisy_ff &&
                       (frame_last || (cs_din_ff && din_rise));

   // Main sequencer.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_ff <= D_IDLE;
      end else begin
         case (state_ff)
            D_IDLE: begin
               if (start) begin
                  state_ff <= D_CONV;
               end
            end
            D_CONV: begin
               if (conv_done) begin
                  if (daisy_ff || busy_end) begin
                     state_ff <= D_SHIFT;
                  end else begin
                     state_ff <= D_ACQ;
                  end
               end
            end
            D_ACQ: begin
               if (start) begin
                  state_ff <= D_CONV;
               end else if (select) begin
                  state_ff <= D_SHIFT;
               end
            end
            D_SHIFT: begin
               if (start) begin
                  state_ff <= D_CONV;
               end else if (shift_end || (daisy_ff && cv_fall)) begin
                  state_ff <= D_IDLE;
               end
            end
            default: begin
               state_ff <= D_IDLE;
            end
         endcase
      end
   end

   // Daisy mode is fixed by the data input level at the start edge.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         daisy_ff  <= 1'b0;
         sample_ff <= '0;
      end else if (start) begin
         daisy_ff  <= ~din_q;
         sample_ff <= i_sample;
      end
   end

   // Remember which line acts as chip select for the readout.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_ff   <= 1'b0;
         cs_din_ff <= 1'b0;
      end else if (conv_done) begin
         busy_ff   <= busy_end;
         cs_din_ff <= cv_q;
      end else if (select) begin
         cs_din_ff <= din_fall;
      end
   end

   // Conversion cycle counter on the internal clock.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_ff <= '0;
      end else if (start) begin
         cnt_ff <= '0;
      end else if (state_ff == D_CONV) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // Count falling serial clock edges within one readout.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         edge_ff <= '0;
      end else if (state_ff != D_SHIFT) begin
         edge_ff <= '0;
      end else if (sclk_fall) begin
         edge_ff <= edge_ff + 8'h01;
      end
   end

   // Output shifter; its top bit is the line level. A leading zero is the busy bit.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sreg_ff <= '0;
      end else if (conv_done) begin
         if (busy_end) begin
            sreg_ff <= {1'b0, sample_ff};
         end else begin
            sreg_ff <= {sample_ff, 1'b0};
         end
      end else if ((state_ff == D_SHIFT) && sclk_fall) begin
         sreg_ff <= {sreg_ff[DATA_W-1:0], daisy_ff & din_q};
      end else if (state_ff == D_IDLE) begin
         sreg_ff <= '0;
      end
   end

   // Output enable. Idle with both inputs low the line is driven low.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         oe_ff <= 1'b0;
      end else if (start) begin
         oe_ff <= 1'b0;
      end else if (conv_done) begin
         oe_ff <= daisy_ff | busy_end;
      end else if (select) begin
         oe_ff <= 1'b1;
      end else if (state_ff == D_SHIFT) begin
         oe_ff <= ~(shift_end || (daisy_ff && cv_fall));
      end else if (state_ff == D_IDLE) begin
         oe_ff <= ~cv_q & ~din_q;
      end
   end

   // Conversion status for the user side.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         conv_ff <= 1'b0;
      end else if (start) begin
         conv_ff <= 1'b1;
      end else if (conv_done) begin
         conv_ff <= 1'b0;
      end
   end

   assign link.dout_o  = sreg_ff[DATA_W];
   assign link.dout_oe = oe_ff;
   assign o_converting = conv_ff;
   assign o_daisy_mode = daisy_ff;
endmodule // adc_readout_device

// [core/adc_readout_host.sv]
// Host end of the serial readout link: drives start, select and clock, collects the result.
`timescale 1ns/100ps
module adc_readout_host
   import adc_readout_pkg::*;
(
   adc_link_if.host                link,
   input  wire logic               i_sys_clk,
   input  wire logic               i_arst_n,
   input  wire logic               i_start,
   input  host_mode_t              i_mode,
   output logic                    o_ready,
   output logic                    o_valid,
   output logic [DATA_W-1:0]       o_data
);
   host_state_t       state_ff;
   host_mode_t        mode_ff;
   logic [7:0]        cnt_ff;
   logic [7:0]        edge_ff;
   logic [7:0]        frame_len;
   logic              conv_ff;
   logic              sdi_ff;
   logic              sclk_ff;
   logic              ready_ff;
   logic              valid_ff;
   logic [DATA_W-1:0] data_ff;
   logic              dout_q;
   logic              busy_mode;
   logic              half_done;

   // The returned data line crosses in from the converter's domain.
   adc_pin_sync #(
      .WIDTH   (1),
      .RST_VAL (RST_DOUT)
   ) u_dout_sync (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     (link.dout),
      .o_q       (dout_q)
   );

   assign busy_mode = (mode_ff == M_3W_BUSY) || (mode_ff == M_4W_BUSY);
   assign frame_len = busy_mode ? FRAME_BUSY : FRAME_PLAIN;
   assign half_done = (cnt_ff == SCLK_HALF_CYC - 8'h01);

   // Sequencer with cycle counter and pin drivers; one process keeps them in step.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_ff <= H_IDLE;
         mode_ff  <= M_3W;
         cnt_ff   <= '0;
         edge_ff  <= '0;
         conv_ff  <= RST_CONV;
         sdi_ff   <= RST_SDI;
         sclk_ff  <= RST_SCLK;
         ready_ff <= 1'b1;
         valid_ff <= 1'b0;
         data_ff  <= '0;
      end else begin
         valid_ff <= 1'b0;
         case (state_ff)
            H_IDLE: begin
               if (i_start) begin
                  mode_ff  <= i_mode;
                  sdi_ff   <= (i_mode != M_DAISY);
                  cnt_ff   <= '0;
                  ready_ff <= 1'b0;
                  state_ff <= H_CONV;
               end
            end
            H_CONV: begin
               cnt_ff <= cnt_ff + 8'h01;
               if (cnt_ff == ARM_CYC) begin
                  conv_ff <= 1'b1;
               end
               if (cnt_ff == HOST_DROP_CYC) begin
                  if (mode_ff == M_3W_BUSY) begin
                     conv_ff <= 1'b0;
                  end
                  if (mode_ff == M_4W_BUSY) begin
                     sdi_ff <= 1'b0;
                  end
               end
               if (cnt_ff == HOST_WAIT_CYC) begin
                  cnt_ff   <= '0;
                  state_ff <= H_WAIT;
               end
            end
            H_WAIT: begin
               // Busy modes wait for the low busy bit, plain three- and four-wire modes select now.
               if (!busy_mode || !dout_q) begin
                  state_ff <= H_SHIFT;
                  edge_ff  <= '0;
               end
               if (mode_ff == M_3W) begin
                  conv_ff <= 1'b0;
               end
               if (mode_ff == M_4W) begin
                  sdi_ff <= 1'b0;
               end
            end
            H_SHIFT: begin
               cnt_ff <= cnt_ff + 8'h01;
               if (half_done) begin
                  cnt_ff  <= '0;
                  sclk_ff <= ~sclk_ff;
                  // Sampling right at the falling edge sees the bit still held.
                  if (sclk_ff) begin
                     data_ff <= {data_ff[DATA_W-2:0], dout_q};
                     edge_ff <= edge_ff + 8'h01;
                     if (edge_ff == frame_len - 8'h01) begin
                        state_ff <= H_DONE;
                     end
                  end
               end
            end
            H_DONE: begin
               // Select rises with start falling, so outside daisy mode the two are never both low.
               sdi_ff   <= (mode_ff != M_DAISY);
               conv_ff  <= 1'b0;
               valid_ff <= 1'b1;
               ready_ff <= 1'b1;
               state_ff <= H_IDLE;
            end
            default: begin
               state_ff <= H_IDLE;
            end
         endcase
      end
   end

   assign link.conv_start = conv_ff;
   assign link.sdi        = sdi_ff;
   assign link.sclk       = sclk_ff;
   assign o_ready         = ready_ff;
   assign o_valid         = valid_ff;
   assign o_data          = data_ff;
endmodule // adc_readout_host

// [tb/adc_link_assertions.sv]
// Concurrent checks on the pins of the converter readout link.
`timescale 1ns/100ps
module adc_link_assertions (
   input  wire logic i_sys_clk,
   input  wire logic i_arst_n,
   input  wire logic conv_start,
   input  wire logic sdi,
   input  wire logic sclk,
   input  wire logic dout_o,
   input  wire logic dout_oe,
   input  wire logic dout
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   logic [4:0] falls_ff;
   logic [7:0] since_fall_ff;
   logic       plain3_ff;

   // Clock falls seen while the output drives, cleared on every release.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         falls_ff <= 5'h00;
      end else if (!dout_oe) begin
         falls_ff <= 5'h00;
      end else if ($fell(sclk) && falls_ff != 5'h1F) begin
         falls_ff <= falls_ff + 5'h01;
      end
   end

   // Cycles since the last clock fall; saturates so a long idle never wraps.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         since_fall_ff <= 8'hFF;
      end else if ($fell(sclk)) begin
         since_fall_ff <= 8'h00;
      end else if (since_fall_ff != 8'hFF) begin
         since_fall_ff <= since_fall_ff + 8'h01;
      end
   end

   // A drive that follows a late start-pin fall is a three-wire frame without busy bit.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         plain3_ff <= 1'b0;
      end else if (!dout_oe) begin
         plain3_ff <= 1'b0;
      end else if ($rose(dout_oe) && !conv_start && $past(conv_start, 16)) begin
         plain3_ff <= 1'b1;
      end
   end

   AST_START_RELEASE: assert property ($rose(conv_start) |-> ##[1:10] !dout_oe)
      else $error("output still driven after start");
   AST_CONV_HOLDS: assert property ($rose(conv_start) |-> ##12 (!dout_oe)[*8]
      ##1 (!dout_oe)[*8] ##1 (!dout_oe)[*8])
      else $error("output driven during conversion");
   AST_BUSY_BIT: assert property ($rose(dout_oe) && !conv_start
      && !$past(conv_start, 16) |-> !dout)
      else $error("busy bit not low");
   AST_FRAME_MAX: assert property (dout_oe |-> falls_ff <= 5'h13)
      else $error("output driven past frame end");
   AST_BUSY_RELEASE: assert property (dout_oe && falls_ff == 5'h13 |-> ##[0:10] !dout_oe)
      else $error("no release after busy frame");
   AST_PLAIN3_RELEASE: assert property (plain3_ff && falls_ff == 5'h12
      |-> ##[0:10] !dout_oe)
      else $error("no release after plain frame");
   AST_FIRST_BIT_STANDS: assert property ($rose(dout_oe)
      |=> ($stable(dout_o) || !dout_oe)[*6])
      else $error("first bit changed without clock");
   AST_SHIFT_ON_FALL: assert property (dout_oe && $past(dout_oe) && $changed(dout_o)
      |-> since_fall_ff <= 8'h0A)
      else $error("bit changed away from clock fall");
   AST_SCLK_HALF: assert property ($changed(sclk) |=> $stable(sclk)[*7])
      else $error("serial clock half period short");
   AST_SELECT_RELEASE: assert property ($rose(sdi) |-> ##[0:10] !dout_oe)
      else $error("output driven after select rise");
endmodule // adc_link_assertions

// [tb/adc_serial_readout_modes_tb_top.sv]
// Self-checking bench joining the converter end and the host end over the link.
`timescale 1ns/100ps
module adc_serial_readout_modes_tb_top;
   import adc_readout_pkg::*;
   logic              i_sys_clk;
   logic              i_arst_n;
   logic              i_start;
   host_mode_t        i_mode;
   logic [DATA_W-1:0] i_sample;
   logic              o_ready;
   logic              o_valid;
   logic [DATA_W-1:0] o_data;
   logic              o_converting;
   logic              o_daisy_mode;
   logic              cs_watch;
   logic              both_low;
   logic              saw_conv;
   int                n_valid;
   int                mismatches;
   int                n_compared;
   host_mode_t        modes [5] = '{M_3W, M_3W_BUSY, M_4W, M_4W_BUSY, M_DAISY};
   logic [DATA_W-1:0] samples [5] = '{18'h2AAAA, 18'h3FFFF, 18'h20001, 18'h15555, 18'h1E0F3};

   adc_link_if link ();
   adc_readout_device i_adc_readout_device (.link(link), .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n), .i_sample(i_sample), .o_converting(o_converting),
      .o_daisy_mode(o_daisy_mode));
   adc_readout_host i_adc_readout_host (.link(link), .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n), .i_start(i_start), .i_mode(i_mode), .o_ready(o_ready),
      .o_valid(o_valid), .o_data(o_data));
   adc_link_assertions i_adc_link_assertions (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .conv_start(link.conv_start), .sdi(link.sdi), .sclk(link.sclk),
      .dout_o(link.dout_o), .dout_oe(link.dout_oe), .dout(link.dout));

   always #10 i_sys_clk = ~i_sys_clk;

   // Pin monitors; both selects low is only legal in daisy mode.
   always @(posedge i_sys_clk) begin
      if (o_converting === 1'b1) begin
         saw_conv <= 1'b1;
      end
      if (cs_watch && link.conv_start === 1'b0 && link.sdi === 1'b0) begin
         both_low <= 1'b1;
      end
      if (o_valid === 1'b1) begin
         n_valid <= n_valid + 1;
      end
   end

   task automatic conclude();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                             input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // Inputs move a fixed 1 ns after the edge so no sampling race can arise.
   task automatic tick();
      @(posedge i_sys_clk);
      #1;
   endtask

   task automatic step(inout int n, input int limit);
      tick();
      n++;
      if (n > limit) begin
         mismatches++;
         $display("wrong value at %0t: wait ran out", $time);
         conclude();
      end
   endtask

   // One full readout; a poke repeats the request while busy, which must be ignored.
   task automatic read_one(input host_mode_t mode, input logic [DATA_W-1:0] value,
                           input bit poke);
      int n;
      n = 0;
      while (o_ready !== 1'b1) step(n, 100);
      i_sample = value;
      i_mode = mode;
      cs_watch = (mode != M_DAISY);
      both_low = 1'b0;
      saw_conv = 1'b0;
      n_valid = 0;
      i_start = 1'b1;
      tick();
      i_start = 1'b0;
      check_bit(o_ready, 1'b0, "request taken");
      if (poke) begin
         repeat (30) tick();
         i_mode = M_3W;
         i_start = 1'b1;
         tick();
         i_start = 1'b0;
      end
      n = 0;
      while (o_valid !== 1'b1) step(n, 3000);
      check_word(o_data, value, "result");
      check_bit(o_daisy_mode, mode == M_DAISY, "daisy select");
      check_bit(saw_conv, 1'b1, "conversion seen");
      check_bit(o_converting, 1'b0, "conversion ended");
      check_bit(both_low, 1'b0, "both selects low");
      repeat (40) tick();
      check_bit(n_valid == 1, 1'b1, "single result");
      // Daisy leaves both selects low, so the line is then driven low.
      check_bit(link.dout_oe, mode == M_DAISY, "line after readout");
      cs_watch = 1'b0;
   endtask

   initial begin
      i_sys_clk = 1'b0;
      i_arst_n = 1'b0;
      i_start = 1'b0;
      i_mode = M_3W;
      i_sample = '0;
      cs_watch = 1'b0;
      mismatches = 0;
      n_compared = 0;
      repeat (10) @(posedge i_sys_clk);
      #1;
      i_arst_n = 1'b1;
      check_bit(link.dout, 1'b1, "idle line");
      // Each mode twice, the second time with the inverted pattern.
      for (int m = 0; m < 5; m++) begin
         read_one(modes[m], samples[m], 1'b0);
         read_one(modes[m], ~samples[m], m == 2);
      end
      // A reset in mid-conversion must leave both ends quiet and ready.
      i_mode = M_4W_BUSY;
      i_start = 1'b1;
      tick();
      i_start = 1'b0;
      repeat (30) tick();
      i_arst_n = 1'b0;
      tick();
      i_arst_n = 1'b1;
      tick();
      check_bit(link.dout_oe, 1'b0, "released after reset");
      read_one(M_4W_BUSY, 18'h0F0F0, 1'b0);
      conclude();
   end
endmodule // adc_serial_readout_modes_tb_top
